// *** psta_table_access.sv ***
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
// Behaviour
// - Program address steps two per word
// - Two parallel 16-bit word spaces
// - Only high ops reach upper byte
// - Low word read returns P[15:0]
// - Low byte read picks by select
// - High word read zeroes phantom byte
// - High byte read, select one gives zero
// - Writes accept byte or word
// - Page pointer selects page, bit7 config
module psta_table_access (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        tbl_req,
    input  wire logic [1:0]  tbl_op,
    input  wire logic        tbl_byte,
    input  wire logic [15:0] tbl_addr,
    input  wire logic [15:0] tbl_wdata,
    output logic             tbl_busy,
    output logic             tbl_done,
    output logic      [15:0] tbl_rdata,
    output logic             pm_rd,
    output logic             pm_wr,
    output logic      [22:0] pm_addr,
    output logic             pm_cfg,
    output logic      [23:0] pm_wdata,
    output logic      [2:0]  pm_lane,
    input  wire logic        pm_ack,
    input  wire logic [23:0] pm_rdata
);
    psta_pkg::psta_regs_t r_r;
    psta_pkg::psta_regs_t r_nxt;

    // Hit when the address equals the byte address of a register index
    function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] idx);
        reg_hit = addr == {idx[9:0], 2'h0};
    endfunction

    always_comb begin
        logic [7:0] sel_byte;
        sel_byte = 8'h00;
        r_nxt = r_r;
        r_nxt.pready = 1'b0;
        r_nxt.pslverr = 1'b0;
        // APB access phase, one wait state
        if (psel && penable && !r_r.pready) begin
            r_nxt.pready = 1'b1;
            r_nxt.prdata = 32'h0000_0000;
            if (reg_hit(paddr, psta_pkg::TABLE_PAGE_POINTER_OFS)) begin
                r_nxt.prdata = {24'h00_0000, r_r.page};
            end else if (reg_hit(paddr, psta_pkg::STATUS_OFS)) begin
                r_nxt.prdata = {r_r.cnt, 13'h0000, r_r.cfg_last, r_r.st == psta_pkg::ST_WAIT, 1'b0};
            end else begin
                r_nxt.pslverr = 1'b1;
            end
        end
        if (psel && penable && r_r.pready && pwrite && reg_hit(paddr, psta_pkg::TABLE_PAGE_POINTER_OFS)) begin
            r_nxt.page = pwdata[7:0];
        end
        case (r_r.st)
            psta_pkg::ST_IDLE: begin
                if (tbl_req) begin
                    r_nxt.st = psta_pkg::ST_WAIT;
                    r_nxt.is_high = tbl_op[0];
                    r_nxt.is_byte = tbl_byte;
                    r_nxt.bsel = tbl_addr[psta_pkg::BYTE_SEL_BIT];
                    r_nxt.cfg_last = r_r.page[psta_pkg::PAGE_CFG_BIT];
                    r_nxt.wdat = tbl_wdata;
                    r_nxt.addr = tbl_addr;
                    r_nxt.op_wr = tbl_op[1];
                end
            end
            psta_pkg::ST_WAIT: begin
                if (pm_ack) begin
                    r_nxt.st = psta_pkg::ST_DONE;
                    r_nxt.cnt = r_r.cnt + 16'h0001;
                    if (!r_r.is_high) begin
                        sel_byte = r_r.bsel ? pm_rdata[15:8] : pm_rdata[7:0];
                        r_nxt.rdata = r_r.is_byte ? {8'h00, sel_byte} : pm_rdata[15:0];
                    end else begin
                        sel_byte = r_r.bsel ? 8'h00 : pm_rdata[23:16];
                        r_nxt.rdata = r_r.is_byte ? {8'h00, sel_byte} : {8'h00, pm_rdata[23:16]};
                    end
                end
            end
            default: r_nxt.st = psta_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_r <= '{st: psta_pkg::ST_IDLE, page: psta_pkg::TABLE_PAGE_RST, default: '0};
        end else begin
            r_r <= r_nxt;
        end
    end

    assign prdata    = r_r.prdata;
    assign pready    = r_r.pready;
    assign pslverr   = r_r.pslverr;
    assign tbl_busy  = r_r.st != psta_pkg::ST_IDLE;
    assign tbl_done  = r_r.st == psta_pkg::ST_DONE;
    assign tbl_rdata = r_r.rdata;
    assign pm_rd     = r_r.st == psta_pkg::ST_WAIT && !r_r.op_wr;
    assign pm_wr     = r_r.st == psta_pkg::ST_WAIT && r_r.op_wr;
    // page and word address, two units per word
    assign pm_addr   = {r_r.page, r_r.addr[15:1]};
    assign pm_cfg    = r_r.page[psta_pkg::PAGE_CFG_BIT];
    // lanes: low space bytes 0-1, high space byte 2 only
    assign pm_wdata  = r_r.is_high ? {r_r.wdat[7:0], 16'h0000}
                     : (r_r.is_byte && r_r.bsel ? {8'h00, r_r.wdat[7:0], 8'h00} : {8'h00, r_r.wdat});
    assign pm_lane   = r_r.is_high ? (r_r.is_byte && r_r.bsel ? 3'h0 : 3'h4)
                     : (r_r.is_byte ? (r_r.bsel ? 3'h2 : 3'h1) : 3'h3);

    property p_high_zero;
        @(posedge pclk) disable iff (!presetn)
        (r_r.st == psta_pkg::ST_WAIT && pm_ack && r_r.is_high) |=> tbl_rdata[15:8] == 8'h00;
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("phantom byte not zero");
    property p_low_word;
        @(posedge pclk) disable iff (!presetn)
        (r_r.st == psta_pkg::ST_WAIT && pm_ack && !r_r.is_high && !r_r.is_byte)
            |=> tbl_rdata == $past(pm_rdata[15:0]);
    endproperty
    a_low_word: assert property (p_low_word) else $error("low word mismatch");
    property p_done;
        @(posedge pclk) disable iff (!presetn)
        (tbl_busy && !tbl_done && pm_ack) |=> tbl_done ##1 !tbl_busy;
    endproperty
    a_done: assert property (p_done) else $error("done sequence wrong");

    property p_page_write;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && reg_hit(paddr, psta_pkg::TABLE_PAGE_POINTER_OFS))
            |=> r_r.page == $past(pwdata[7:0]);
    endproperty
    a_page_write: assert property (p_page_write) else $error("pointer write lost");

    property p_page_upper;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && reg_hit(paddr, psta_pkg::TABLE_PAGE_POINTER_OFS))
            |-> prdata[31:8] == 24'h00_0000;
    endproperty
    a_page_upper: assert property (p_page_upper) else $error("pointer upper bits set");

    property p_unmapped;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && !reg_hit(paddr, psta_pkg::TABLE_PAGE_POINTER_OFS)
            && !reg_hit(paddr, psta_pkg::STATUS_OFS)) |-> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

    property p_pready_pulse;
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("ready longer than one cycle");

    property p_low_byte;
        @(posedge pclk) disable iff (!presetn)
        (r_r.st == psta_pkg::ST_WAIT && pm_ack && !r_r.is_high && r_r.is_byte)
            |=> tbl_rdata == {8'h00, $past(r_r.bsel) ? $past(pm_rdata[15:8]) : $past(pm_rdata[7:0])};
    endproperty
    a_low_byte: assert property (p_low_byte) else $error("low byte pick wrong");

    property p_high_word;
        @(posedge pclk) disable iff (!presetn)
        (r_r.st == psta_pkg::ST_WAIT && pm_ack && r_r.is_high && !r_r.is_byte)
            |=> tbl_rdata == {8'h00, $past(pm_rdata[23:16])};
    endproperty
    a_high_word: assert property (p_high_word) else $error("high word wrong");

    property p_high_sel;
        @(posedge pclk) disable iff (!presetn)
        (r_r.st == psta_pkg::ST_WAIT && pm_ack && r_r.is_high && r_r.is_byte && r_r.bsel)
            |=> tbl_rdata == 16'h0000;
    endproperty
    a_high_sel: assert property (p_high_sel) else $error("phantom byte read not zero");

    property p_high_lane;
        @(posedge pclk) disable iff (!presetn)
        (pm_wr && r_r.is_high)
            |-> pm_lane[1:0] == 2'h0;
    endproperty
    a_high_lane: assert property (p_high_lane) else $error("high write reaches low word");

    property p_word_lane;
        @(posedge pclk) disable iff (!presetn)
        (pm_wr && !r_r.is_high && !r_r.is_byte)
            |-> pm_lane == 3'h3;
    endproperty
    a_word_lane: assert property (p_word_lane) else $error("low word write lanes wrong");

    property p_word_addr;
        @(posedge pclk) disable iff (!presetn)
        (r_r.st == psta_pkg::ST_IDLE && tbl_req)
            |=> pm_addr[14:0] == $past(tbl_addr[15:1]);
    endproperty
    a_word_addr: assert property (p_word_addr) else $error("word address wrong");

    property p_cfg_take;
        @(posedge pclk) disable iff (!presetn)
        (r_r.st == psta_pkg::ST_IDLE && tbl_req)
            |=> r_r.cfg_last == $past(r_r.page[psta_pkg::PAGE_CFG_BIT]);
    endproperty
    a_cfg_take: assert property (p_cfg_take) else $error("config page not taken");

    property p_req_hold;
        @(posedge pclk) disable iff (!presetn)
        ((pm_rd || pm_wr) && !pm_ack)
            |=> (pm_rd || pm_wr);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("flash request dropped early");
endmodule // psta_table_access

// *** psta_pkg.sv ***
package psta_pkg;
    // Register indices, APB byte address is four times the index
    localparam logic [11:0] TABLE_PAGE_POINTER_OFS = 12'h032;
    localparam logic [11:0] STATUS_OFS             = 12'h010;
    localparam logic [7:0]  TABLE_PAGE_RST         = 8'h00;
    // Field positions
    localparam int          PAGE_CFG_BIT           = 7;
    localparam int          BYTE_SEL_BIT           = 0;
    // Operation codes
    localparam logic [1:0]  OP_READ_LOW            = 2'h0;
    localparam logic [1:0]  OP_READ_HIGH           = 2'h1;
    localparam logic [1:0]  OP_WRITE_LOW           = 2'h2;
    localparam logic [1:0]  OP_WRITE_HIGH          = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_DONE = 3'b100
    } psta_state_t;

    typedef struct packed {
        psta_state_t st;
        logic [7:0]  page;
        logic        is_high;
        logic        is_byte;
        logic        bsel;
        logic [15:0] rdata;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        cfg_last;
        logic [15:0] cnt;
        logic [15:0] wdat;
        logic [15:0] addr;
        logic        op_wr;
    } psta_regs_t;
endpackage

// *** psta_flash_model.sv ***
`timescale 1ns/1ps
module psta_flash_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pm_rd,
    input  wire logic        pm_wr,
    input  wire logic [22:0] pm_addr,
    output logic             pm_ack,
    output logic      [23:0] pm_rdata
);
    logic [1:0] cnt_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r  <= 2'h0;
            pm_ack <= 1'h0;
        end else begin
            cnt_r  <= (pm_rd | pm_wr) && !pm_ack ? cnt_r + 2'h1 : 2'h0;
            pm_ack <= (pm_rd | pm_wr) && !pm_ack && cnt_r == pm_addr[4:3];
        end
    end
    assign pm_rdata = pm_ack ? {pm_addr[7:0] ^ 8'h3C, pm_addr[15:0] ^ 16'hA5F0} : {1'h1, ~pm_addr};
endmodule // psta_flash_model

// *** tb_psta_table_access.sv ***
`timescale 1ns/1ps
module tb_psta_table_access;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        tbl_req, tbl_byte, tbl_done, tbl_busy, pm_rd, pm_wr, pm_cfg, pm_ack;
    logic [1:0]  tbl_op;
    logic [2:0]  pm_lane;
    logic [11:0] paddr;
    logic [15:0] tbl_addr, tbl_wdata, tbl_rdata;
    logic [22:0] pm_addr;
    logic [23:0] pm_wdata, pm_rdata;
    logic [31:0] pwdata, prdata, rd;
    int          mismatches, check_count, ops_total;
    psta_table_access i_psta_table_access (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .tbl_req, .tbl_op, .tbl_byte, .tbl_addr, .tbl_wdata, .tbl_busy,
        .tbl_done, .tbl_rdata, .pm_rd, .pm_wr, .pm_addr, .pm_cfg, .pm_wdata, .pm_lane, .pm_ack, .pm_rdata);
    psta_flash_model i_psta_flash_model (.pclk, .presetn, .pm_rd, .pm_wr, .pm_addr, .pm_ack, .pm_rdata);
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= {a[9:0], 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic tbl(logic [7:0] pg, int k, output logic [15:0] r, output logic [2:0] ln,
                       output logic [23:0] wd);
        logic [15:0] a;
        a = {8'hB6, 4'(k), 3'h2, k[0]};
        tbl_req <= 1'h1;
        tbl_op <= k[3:2];
        tbl_byte <= k[1];
        tbl_addr <= a;
        @(posedge pclk);
        tbl_req <= 1'h0;
        do @(posedge pclk); while (!(pm_rd | pm_wr | tbl_done));
        ln = pm_lane;
        wd = pm_wdata;
        chk("busy", tbl_busy, 32'h1);
        chk("pm_wr", pm_wr, k[3]);
        chk("pm_addr", pm_addr, {pg, a[15:1]});
        chk("pm_cfg", pm_cfg, pg[7]);
        while (tbl_done !== 1'h1) @(posedge pclk);
        r = tbl_rdata;
        ops_total++;
        @(posedge pclk);
    endtask
    task automatic t_regs;
        apb(1'h0, psta_pkg::TABLE_PAGE_POINTER_OFS, 32'h0);
        chk("page_rst", rd, 32'h0);
        apb(1'h1, psta_pkg::TABLE_PAGE_POINTER_OFS, 32'hFFFFFFFF);
        apb(1'h0, psta_pkg::TABLE_PAGE_POINTER_OFS, 32'h0);
        chk("page_rd", rd, 32'h000000FF);
        apb(1'h0, 12'h100, 32'h0);
        chk("slverr", err, 32'h1);
        $display("test regs done");
    endtask
    task automatic t_ops(logic [7:0] pg);
        logic [15:0] r, e;
        logic [2:0]  ln, el;
        logic [22:0] pa;
        logic [23:0] w, wd, ew;
        apb(1'h1, psta_pkg::TABLE_PAGE_POINTER_OFS, {24'hFFFF00, pg});
        for (int k = 0; k < 16; k++) begin
            tbl(pg, k, r, ln, wd);
            ew = k[2] ? {tbl_wdata[7:0], 16'h0000}
               : (k[1] & k[0] ? {8'h00, tbl_wdata[7:0], 8'h00} : {8'h00, tbl_wdata});
            pa = {pg, 8'hB6, 4'(k), 3'h2};
            w = {pa[7:0] ^ 8'h3C, pa[15:0] ^ 16'hA5F0};
            case (k[3:1])
                3'h0: e = w[15:0];
                3'h1: e = {8'h00, k[0] ? w[15:8] : w[7:0]};
                3'h2: e = {8'h00, w[23:16]};
                3'h3: e = {8'h00, k[0] ? 8'h00 : w[23:16]};
                default: e = 16'h0;
            endcase
            el = !k[2] ? (k[1] ? (k[0] ? 3'h2 : 3'h1) : 3'h3) : (k[1] & k[0] ? 3'h0 : 3'h4);
            if (k < 8) chk("rdata", r, e);
            else chk("lane", ln, el);
            if (k >= 8) chk("pm_wdata", wd, ew);
        end
        apb(1'h0, psta_pkg::STATUS_OFS, 32'h0);
        chk("status", rd, {16'(ops_total), 13'h0000, pg[7], 2'h0});
        $display("test ops page %h done", pg);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        pclk = 1'h0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        #100000;
        mismatches++;
        stop_test;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, tbl_req, tbl_op, tbl_byte, tbl_addr} = '0;
        ops_total = 0;
        tbl_wdata = 16'h9C61;
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        t_regs;
        t_ops(8'h00);
        t_ops(8'h85);
        stop_test;
    end
endmodule // tb_psta_table_access
